// File: optic_cfg_consts.svh
`ifndef OPTIC_CFG_CONSTS_SVH
`define OPTIC_CFG_CONSTS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define OFS_LOGIC_CONFIGURATION 8'h89
`define OFS_RANGE_FORCE_CONTROL 8'h8A
`define OFS_RESERVED_8B 8'h8B
`define OFS_MAIN_SLAVE_ADDRESS 8'h8C
`define OFS_RESERVED_8D 8'h8D
`define OFS_MONITOR_SHIFT_CONTROL 8'h8E

// ************************************************************
// Reset values and writable masks
// ************************************************************
`define RST_LOGIC_CONFIGURATION 8'h00
`define RST_RANGE_FORCE_CONTROL 8'h00
`define RST_MAIN_SLAVE_ADDRESS 8'hA2
`define RST_MONITOR_SHIFT_CONTROL 8'h00
`define MASK_LOGIC_CONFIGURATION 8'h5D
`define MASK_RANGE_FORCE_CONTROL 8'h03
`define MASK_MONITOR_SHIFT_CONTROL 8'h77
`define READ_ZERO 8'h00

// ************************************************************
// Field positions
// ************************************************************
`define BIT_LOSS_SOURCE_SELECT 6
`define BIT_ADDRESS_SELECT 4
`define BIT_LAYOUT_SELECT 3
`define BIT_TX_FAULT_POLARITY 2
`define BIT_RX_ABSENT_POLARITY 0
`define BIT_FORCE_COARSE_RANGE 1
`define BIT_FORCE_FINE_RANGE 0
`define FLD_SHIFT_ONE_HI 6
`define FLD_SHIFT_ONE_LO 4
`define FLD_SHIFT_TWO_HI 2
`define FLD_SHIFT_TWO_LO 0

// ************************************************************
// Serial slave addresses (upper seven bits are compared)
// ************************************************************
`define FIXED_MAIN_ADDRESS 8'hA2
`define IDENT_MEMORY_ADDRESS 8'hA0

`endif

// File: optic_cfg_pkg.sv
`default_nettype none

package optic_cfg_pkg;

	typedef enum logic [1:0]
	{
		RANGE_AUTO,
		RANGE_COARSE,
		RANGE_FINE
	} range_choice_t;

endpackage

`default_nettype wire

// File: monitor_shifter.sv
`timescale 1ns/10ps
`default_nettype none

module monitor_shifter #(
	parameter int DATA_W = 16,
	parameter int SHIFT_W = 3
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Result path
	input wire logic [DATA_W-1:0] result_in,
	input wire logic [SHIFT_W-1:0] shift_amount,
	output logic [DATA_W-1:0] result_out
);

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			result_out <= '0;
		else
			result_out <= result_in >> shift_amount;
	end

	a_shift_result: assert property (@(posedge core_clk) disable iff (!resetn)
		1'b1 |=> result_out == ($past(result_in) >> $past(shift_amount)))
		else $error("Monitor result not shifted by the programmed amount.");

endmodule
`default_nettype wire

// File: range_selector.sv
`timescale 1ns/10ps
`default_nettype none

module range_selector
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Control
	input wire logic force_coarse_range,
	input wire logic force_fine_range,
	input wire logic auto_pick_coarse,
	// Result
	output var optic_cfg_pkg::range_choice_t range_choice,
	output logic use_coarse_range
);

	optic_cfg_pkg::range_choice_t choice_nxt;

	// Coarse wins when both forces are set.
	always_comb
	begin
		if (force_coarse_range)
			choice_nxt = optic_cfg_pkg::RANGE_COARSE;
		else if (force_fine_range)
			choice_nxt = optic_cfg_pkg::RANGE_FINE;
		else
			choice_nxt = optic_cfg_pkg::RANGE_AUTO;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			range_choice <= optic_cfg_pkg::RANGE_AUTO;
			use_coarse_range <= 1'b0;
		end
		else
		begin
			range_choice <= choice_nxt;
			case (choice_nxt)
				optic_cfg_pkg::RANGE_COARSE: use_coarse_range <= 1'b1;
				optic_cfg_pkg::RANGE_FINE: use_coarse_range <= 1'b0;
				optic_cfg_pkg::RANGE_AUTO: use_coarse_range <= auto_pick_coarse;
				default: use_coarse_range <= 1'b0;
			endcase
		end
	end

	a_coarse_priority: assert property (@(posedge core_clk) disable iff (!resetn)
		force_coarse_range |=> use_coarse_range)
		else $error("Forced coarse range not applied.");

	a_fine_forced: assert property (@(posedge core_clk) disable iff (!resetn)
		(force_fine_range && !force_coarse_range) |=> !use_coarse_range)
		else $error("Forced fine range not applied.");

endmodule
`default_nettype wire

// File: optic_module_logic_config_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "optic_cfg_consts.svh"

// Overview of operation
// - Loss source 0: loss flag set while third channel result is below threshold.
// - Loss source 1: loss flag follows the external loss input.
// - Address select 0: main memory answers at fixed address A2h.
// - Address select 1: main memory answers at the programmed address register.
// - Programmed address supports 128 distinct values.
// - Programmed A0h with select 1 silences identification memory.
// - Layout bit picks default or alternate map, effective next command.
// - Internal transmit fault is polarity bit XOR external fault input.
// - Receive loss output is polarity bit XOR external loss input.
// - Force-coarse bit makes third channel use coarse measurement only.
// - Force-fine bit makes third channel use fine measurement only.
// - Both force bits set selects coarse measurement.
// - First channel result right-shifted by bits 6 to 4.
// - Second channel result right-shifted by bits 2 to 0.
// - Unused configuration bits and range bits 7 to 2 have no effect.
// - Shadow select 0 commits writes to nonvolatile store, 1 keeps volatile.
module optic_module_logic_config_regs #(
	parameter int DATA_W = 16
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Byte access from the two-wire serial engine
	input wire logic reg_wr_stb,
	input wire logic reg_rd_stb,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Slave address decode for the serial engine
	input wire logic [7:0] serial_dev_addr,
	output logic addr_match_main,
	output logic addr_match_ident,
	output logic alt_layout_select,
	// Shadow storage control
	input wire logic shadow_select,
	output logic nv_store_req,
	output logic [7:0] nv_store_addr,
	output logic [7:0] nv_store_data,
	// Loss and fault signals
	input wire logic ext_absent_input,
	input wire logic ext_tx_fault_input,
	input wire logic [DATA_W-1:0] monitor_channel_three,
	input wire logic [DATA_W-1:0] loss_threshold,
	output logic signal_absent_flag,
	output logic rx_absent_output,
	output logic tx_fault_internal,
	// Third channel range choice
	input wire logic auto_pick_coarse,
	output var optic_cfg_pkg::range_choice_t range_choice,
	output logic use_coarse_range,
	// First and second channel results
	input wire logic [DATA_W-1:0] monitor_channel_one,
	input wire logic [DATA_W-1:0] monitor_channel_two,
	output logic [DATA_W-1:0] monitor_one_scaled,
	output logic [DATA_W-1:0] monitor_two_scaled
);

	// ************************************************************
	// Register storage
	// ************************************************************
	logic [7:0] logic_configuration_r;
	logic [7:0] range_force_control_r;
	logic [7:0] main_slave_address_r;
	logic [7:0] monitor_shift_control_r;
	logic mapped_wr;

	always_comb
	begin
		case (reg_addr)
			`OFS_LOGIC_CONFIGURATION,
			`OFS_RANGE_FORCE_CONTROL,
			`OFS_MAIN_SLAVE_ADDRESS,
			`OFS_MONITOR_SHIFT_CONTROL: mapped_wr = reg_wr_stb;
			default: mapped_wr = 1'b0;
		endcase
	end

	// Unused configuration, range and shift bits are masked at write time so they can never steer logic.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			logic_configuration_r <= `RST_LOGIC_CONFIGURATION;
			range_force_control_r <= `RST_RANGE_FORCE_CONTROL;
			main_slave_address_r <= `RST_MAIN_SLAVE_ADDRESS;
			monitor_shift_control_r <= `RST_MONITOR_SHIFT_CONTROL;
		end
		else if (reg_wr_stb)
		begin
			case (reg_addr)
				`OFS_LOGIC_CONFIGURATION:
					logic_configuration_r <= reg_wdata & `MASK_LOGIC_CONFIGURATION;
				`OFS_RANGE_FORCE_CONTROL:
					range_force_control_r <= reg_wdata & `MASK_RANGE_FORCE_CONTROL;
				`OFS_MAIN_SLAVE_ADDRESS:
					main_slave_address_r <= reg_wdata;
				`OFS_MONITOR_SHIFT_CONTROL:
					monitor_shift_control_r <= reg_wdata & `MASK_MONITOR_SHIFT_CONTROL;
				default:
					logic_configuration_r <= logic_configuration_r;
			endcase
		end
	end

	// ************************************************************
	// Read port
	// ************************************************************
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			reg_rdata <= `READ_ZERO;
		else if (reg_rd_stb)
		begin
			case (reg_addr)
				`OFS_LOGIC_CONFIGURATION: reg_rdata <= logic_configuration_r;
				`OFS_RANGE_FORCE_CONTROL: reg_rdata <= range_force_control_r;
				`OFS_MAIN_SLAVE_ADDRESS: reg_rdata <= main_slave_address_r;
				`OFS_MONITOR_SHIFT_CONTROL: reg_rdata <= monitor_shift_control_r;
				default: reg_rdata <= `READ_ZERO;
			endcase
		end
	end

	// ************************************************************
	// Shadow storage commit
	// ************************************************************
	// While the shadow is nonvolatile, each accepted write is passed on for storing.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			nv_store_req <= 1'b0;
			nv_store_addr <= `READ_ZERO;
			nv_store_data <= `READ_ZERO;
		end
		else
		begin
			nv_store_req <= mapped_wr && !shadow_select;
			if (mapped_wr && !shadow_select)
			begin
				nv_store_addr <= reg_addr;
				nv_store_data <= reg_wdata;
			end
		end
	end

	// ************************************************************
	// Slave address decode
	// ************************************************************
	logic addr_sel;
	logic [6:0] main_addr7;
	logic ident_silenced;
	logic [7:0] fixed_main_addr;
	logic [7:0] ident_addr;

	// The read/write bit of the address byte is ignored, giving 128 addresses.
	assign fixed_main_addr = `FIXED_MAIN_ADDRESS;
	assign ident_addr = `IDENT_MEMORY_ADDRESS;
	assign addr_sel = logic_configuration_r[`BIT_ADDRESS_SELECT];
	assign main_addr7 = addr_sel ? main_slave_address_r[7:1] : fixed_main_addr[7:1];
	assign ident_silenced = addr_sel && (main_slave_address_r[7:1] == ident_addr[7:1]);
	assign addr_match_main = serial_dev_addr[7:1] == main_addr7;
	assign addr_match_ident = !ident_silenced && (serial_dev_addr[7:1] == ident_addr[7:1]);
	// Taken straight from the register so the very next command sees the new map.
	assign alt_layout_select = logic_configuration_r[`BIT_LAYOUT_SELECT];

	// ************************************************************
	// Loss and fault logic
	// ************************************************************
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			signal_absent_flag <= 1'b0;
			rx_absent_output <= 1'b0;
			tx_fault_internal <= 1'b0;
		end
		else
		begin
			if (logic_configuration_r[`BIT_LOSS_SOURCE_SELECT])
				signal_absent_flag <= ext_absent_input;
			else
				signal_absent_flag <= monitor_channel_three < loss_threshold;
			rx_absent_output <= logic_configuration_r[`BIT_RX_ABSENT_POLARITY] ^ ext_absent_input;
			tx_fault_internal <= logic_configuration_r[`BIT_TX_FAULT_POLARITY] ^ ext_tx_fault_input;
		end
	end

	// ************************************************************
	// Third channel range and channel scaling
	// ************************************************************
	range_selector u_range
	(
		.core_clk(core_clk),
		.resetn(resetn),
		.force_coarse_range(range_force_control_r[`BIT_FORCE_COARSE_RANGE]),
		.force_fine_range(range_force_control_r[`BIT_FORCE_FINE_RANGE]),
		.auto_pick_coarse(auto_pick_coarse),
		.range_choice(range_choice),
		.use_coarse_range(use_coarse_range)
	);

	monitor_shifter #(.DATA_W(DATA_W), .SHIFT_W(3)) u_shift_one
	(
		.core_clk(core_clk),
		.resetn(resetn),
		.result_in(monitor_channel_one),
		.shift_amount(monitor_shift_control_r[`FLD_SHIFT_ONE_HI:`FLD_SHIFT_ONE_LO]),
		.result_out(monitor_one_scaled)
	);

	monitor_shifter #(.DATA_W(DATA_W), .SHIFT_W(3)) u_shift_two
	(
		.core_clk(core_clk),
		.resetn(resetn),
		.result_in(monitor_channel_two),
		.shift_amount(monitor_shift_control_r[`FLD_SHIFT_TWO_HI:`FLD_SHIFT_TWO_LO]),
		.result_out(monitor_two_scaled)
	);

	// ************************************************************
	// Checks
	// ************************************************************
	a_loss_analog: assert property (@(posedge core_clk) disable iff (!resetn)
		!logic_configuration_r[`BIT_LOSS_SOURCE_SELECT]
		|=> signal_absent_flag == ($past(monitor_channel_three) < $past(loss_threshold)))
		else $error("Analog loss comparison wrong.");

	a_loss_digital: assert property (@(posedge core_clk) disable iff (!resetn)
		logic_configuration_r[`BIT_LOSS_SOURCE_SELECT] |=> signal_absent_flag == $past(ext_absent_input))
		else $error("Digital loss source not followed.");

	a_fixed_address: assert property (@(posedge core_clk) disable iff (!resetn)
		!logic_configuration_r[`BIT_ADDRESS_SELECT]
		|-> addr_match_main == (serial_dev_addr[7:1] == fixed_main_addr[7:1]))
		else $error("Fixed main address not used.");

	a_prog_address: assert property (@(posedge core_clk) disable iff (!resetn)
		logic_configuration_r[`BIT_ADDRESS_SELECT]
		|-> addr_match_main == (serial_dev_addr[7:1] == main_slave_address_r[7:1]))
		else $error("Programmed main address not used.");

	a_ident_silent: assert property (@(posedge core_clk) disable iff (!resetn)
		(logic_configuration_r[`BIT_ADDRESS_SELECT] && main_slave_address_r[7:1] == ident_addr[7:1])
		|-> !addr_match_ident)
		else $error("Identification memory still answers.");

	a_ident_decode: assert property (@(posedge core_clk) disable iff (!resetn)
		(!logic_configuration_r[`BIT_ADDRESS_SELECT] && serial_dev_addr[7:1] == ident_addr[7:1])
		|-> addr_match_ident)
		else $error("Identification memory lost under fixed addressing.");

	a_addr_store: assert property (@(posedge core_clk) disable iff (!resetn)
		(reg_wr_stb && reg_addr == `OFS_MAIN_SLAVE_ADDRESS)
		|=> main_slave_address_r[7:1] == $past(reg_wdata[7:1]))
		else $error("Programmed main address lost bits.");

	a_layout_next: assert property (@(posedge core_clk) disable iff (!resetn)
		(reg_wr_stb && reg_addr == `OFS_LOGIC_CONFIGURATION)
		|=> alt_layout_select == $past(reg_wdata[`BIT_LAYOUT_SELECT]))
		else $error("Layout select not effective after write.");

	a_tx_fault_xor: assert property (@(posedge core_clk) disable iff (!resetn)
		1'b1 |=> tx_fault_internal ==
		($past(logic_configuration_r[`BIT_TX_FAULT_POLARITY]) ^ $past(ext_tx_fault_input)))
		else $error("Transmit fault polarity wrong.");

	a_rx_absent_xor: assert property (@(posedge core_clk) disable iff (!resetn)
		1'b1 |=> rx_absent_output ==
		($past(logic_configuration_r[`BIT_RX_ABSENT_POLARITY]) ^ $past(ext_absent_input)))
		else $error("Receive loss polarity wrong.");

	a_unused_zero: assert property (@(posedge core_clk) disable iff (!resetn)
		(logic_configuration_r & ~`MASK_LOGIC_CONFIGURATION) == 8'h00
		&& (range_force_control_r & ~`MASK_RANGE_FORCE_CONTROL) == 8'h00)
		else $error("Unused configuration bits were stored.");

	a_reserved_read: assert property (@(posedge core_clk) disable iff (!resetn)
		(reg_rd_stb && (reg_addr == `OFS_RESERVED_8B || reg_addr == `OFS_RESERVED_8D))
		|=> reg_rdata == 8'h00)
		else $error("Reserved location read nonzero.");

	a_reserved_write: assert property (@(posedge core_clk) disable iff (!resetn)
		(reg_wr_stb && (reg_addr == `OFS_RESERVED_8B || reg_addr == `OFS_RESERVED_8D))
		|=> $stable(logic_configuration_r) && $stable(range_force_control_r)
		&& $stable(main_slave_address_r) && $stable(monitor_shift_control_r))
		else $error("Reserved location write changed a register.");

	a_shift_wiring: assert property (@(posedge core_clk) disable iff (!resetn)
		1'b1 |=> monitor_one_scaled == ($past(monitor_channel_one)
		>> $past(monitor_shift_control_r[`FLD_SHIFT_ONE_HI:`FLD_SHIFT_ONE_LO]))
		&& monitor_two_scaled == ($past(monitor_channel_two)
		>> $past(monitor_shift_control_r[`FLD_SHIFT_TWO_HI:`FLD_SHIFT_TWO_LO])))
		else $error("Channel scaling does not follow the shift fields.");

	a_shadow_commit: assert property (@(posedge core_clk) disable iff (!resetn)
		(mapped_wr && !shadow_select) |=> nv_store_req && nv_store_data == $past(reg_wdata))
		else $error("Nonvolatile commit missing.");

	a_shadow_volatile: assert property (@(posedge core_clk) disable iff (!resetn)
		shadow_select |=> !nv_store_req)
		else $error("Commit issued while shadow is volatile.");

endmodule
`default_nettype wire

// File: serial_engine_model.sv
`timescale 1ns/10ps
`default_nettype none

// ********
// Serial engine byte-access model
// ********
module serial_engine_model
(
	// Clock
	input wire logic core_clk,
	// Byte access
	output logic reg_wr_stb,
	output logic reg_rd_stb,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial
	begin
		reg_wr_stb = 1'b0;
		reg_rd_stb = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// Released lines show the inverse of the last byte, so a stale value is never trusted.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr_stb = 1'b1;
		@(posedge core_clk);
		#1;
		reg_wr_stb = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_rd_stb = 1'b1;
		@(posedge core_clk);
		#1;
		d = reg_rdata;
		reg_rd_stb = 1'b0;
		reg_addr = ~a;
	endtask
endmodule

`default_nettype wire

// File: tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	logic core_clk, resetn, reg_wr_stb, reg_rd_stb, shadow_select, auto_pick_coarse;
	logic ext_absent_input, ext_tx_fault_input, addr_match_main, addr_match_ident;
	logic alt_layout_select, nv_store_req, signal_absent_flag, rx_absent_output;
	logic tx_fault_internal, use_coarse_range;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, serial_dev_addr, nv_store_addr;
	logic [7:0] nv_store_data, rd_val;
	logic [15:0] monitor_channel_one, monitor_channel_two, monitor_channel_three;
	logic [15:0] loss_threshold, monitor_one_scaled, monitor_two_scaled;
	optic_cfg_pkg::range_choice_t range_choice, ec;
	int n_errors = 0;
	int checks = 0;
	int cycles = 0;
	logic [7:0] ra [8] = '{8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h00, 8'hFF};
	logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'hA2, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] fv [8] = '{8'h5D, 8'h03, 8'h00, 8'hFF, 8'h00, 8'h77, 8'h00, 8'h00};
	logic [7:0] mp = 8'h2B;

	optic_module_logic_config_regs #(.DATA_W(16)) uut
	(
		.core_clk(core_clk), .resetn(resetn), .reg_wr_stb(reg_wr_stb),
		.reg_rd_stb(reg_rd_stb), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .serial_dev_addr(serial_dev_addr),
		.addr_match_main(addr_match_main), .addr_match_ident(addr_match_ident),
		.alt_layout_select(alt_layout_select), .shadow_select(shadow_select),
		.nv_store_req(nv_store_req), .nv_store_addr(nv_store_addr),
		.nv_store_data(nv_store_data), .ext_absent_input(ext_absent_input),
		.ext_tx_fault_input(ext_tx_fault_input), .monitor_channel_three(monitor_channel_three),
		.loss_threshold(loss_threshold), .signal_absent_flag(signal_absent_flag),
		.rx_absent_output(rx_absent_output), .tx_fault_internal(tx_fault_internal),
		.auto_pick_coarse(auto_pick_coarse), .range_choice(range_choice),
		.use_coarse_range(use_coarse_range), .monitor_channel_one(monitor_channel_one),
		.monitor_channel_two(monitor_channel_two), .monitor_one_scaled(monitor_one_scaled),
		.monitor_two_scaled(monitor_two_scaled)
	);

	serial_engine_model host
	(
		.core_clk(core_clk), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
	);

	// ********
	// Clock, timeout and verdict
	// ********
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// The whole run needs about 600 cycles; the ceiling leaves ample margin.
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			print_verdict();
		end
	end

	// ********
	// Compare and access helpers
	// ********
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		chk({15'h0000, got}, {15'h0000, exp});
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, rd_val);
		chk({8'h00, rd_val}, {8'h00, e});
	endtask

	task automatic tick;
		@(posedge core_clk);
		#1;
	endtask

	task automatic achk(input logic [7:0] dev, input logic em, input logic ei);
		tick();
		serial_dev_addr = dev;
		#1;
		chk1(addr_match_main, em);
		chk1(addr_match_ident, ei);
	endtask

	// ********
	// Main sequence
	// ********
	initial
	begin
		resetn = 1'b0;
		shadow_select = 1'b0;
		auto_pick_coarse = 1'b0;
		ext_absent_input = 1'b0;
		ext_tx_fault_input = 1'b0;
		serial_dev_addr = 8'hA2;
		monitor_channel_one = 16'h0000;
		monitor_channel_two = 16'h0000;
		monitor_channel_three = 16'h0000;
		loss_threshold = 16'h0000;
		repeat (16) @(posedge core_clk);
		#1;
		resetn = 1'b1;
		for (int i = 0; i < 8; i++)
			rchk(ra[i], rv[i]);
		achk(8'hA3, 1'b1, 1'b0);
		achk(8'hA1, 1'b0, 1'b1);
		for (int i = 0; i < 8; i++)
		begin
			host.wr(ra[i], 8'hFF);
			chk1(nv_store_req, mp[i]);
			if (mp[i])
				chk({nv_store_addr, nv_store_data}, {ra[i], 8'hFF});
			if (i == 0)
				chk1(alt_layout_select, 1'b1);
		end
		for (int i = 0; i < 8; i++)
			rchk(ra[i], fv[i]);
		shadow_select = 1'b1;
		host.wr(8'h89, 8'h00);
		chk1(nv_store_req, 1'b0);
		chk1(alt_layout_select, 1'b0);
		for (int i = 0; i < 16; i++)
		begin
			host.wr(8'h89, {5'h00, i[3], 1'b0, i[2]});
			ext_tx_fault_input = i[1];
			ext_absent_input = i[0];
			tick();
			chk1(tx_fault_internal, i[3] ^ i[1]);
			chk1(rx_absent_output, i[2] ^ i[0]);
		end
		loss_threshold = 16'h0100;
		host.wr(8'h89, 8'h00);
		ext_absent_input = 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			monitor_channel_three = 16'h00FF + 16'(i);
			tick();
			chk1(signal_absent_flag, i == 0);
		end
		host.wr(8'h89, 8'h40);
		monitor_channel_three = 16'h0000;
		for (int i = 0; i < 2; i++)
		begin
			ext_absent_input = i[0];
			tick();
			chk1(signal_absent_flag, i[0]);
		end
		host.wr(8'h8C, 8'h70);
		host.wr(8'h89, 8'h00);
		achk(8'hA2, 1'b1, 1'b0);
		achk(8'h70, 1'b0, 1'b0);
		host.wr(8'h89, 8'h10);
		achk(8'h71, 1'b1, 1'b0);
		achk(8'hA2, 1'b0, 1'b0);
		achk(8'hA0, 1'b0, 1'b1);
		for (int k = 0; k < 128; k++)
		begin
			host.wr(8'h8C, 8'(2 * k));
			achk(8'(2 * k + 1), 1'b1, 1'b0);
		end
		host.wr(8'h8C, 8'hA0);
		achk(8'hA0, 1'b1, 1'b0);
		for (int i = 0; i < 16; i++)
		begin
			host.wr(8'h8A, {(i[3] ? 6'h3F : 6'h00), i[1], i[0]});
			auto_pick_coarse = i[2];
			tick();
			ec = i[1] ? optic_cfg_pkg::RANGE_COARSE :
				(i[0] ? optic_cfg_pkg::RANGE_FINE : optic_cfg_pkg::RANGE_AUTO);
			chk({14'h0000, range_choice}, {14'h0000, ec});
			chk1(use_coarse_range, i[1] | (~i[0] & i[2]));
		end
		host.wr(8'h8A, 8'h01);
		auto_pick_coarse = 1'b1;
		tick();
		chk1(use_coarse_range, 1'b0);
		monitor_channel_one = 16'hFFFF;
		monitor_channel_two = 16'h8000;
		for (int s = 0; s < 8; s++)
		begin
			host.wr(8'h8E, {1'b1, s[2:0], 1'b1, 3'(7 - s)});
			tick();
			chk(monitor_one_scaled, 16'hFFFF >> s);
			chk(monitor_two_scaled, 16'h8000 >> (7 - s));
		end
		// A second reset in mid-run must bring the table back to its start values.
		resetn = 1'b0;
		tick();
		tick();
		resetn = 1'b1;
		rchk(8'h8C, 8'hA2);
		rchk(8'h8E, 8'h00);
		print_verdict();
	end
endmodule

`default_nettype wire
